/* File: hdl/icc_top.sv */
// input capture control top: apb registers, source select, event counting
// assumes pin and timer inputs synchronous to CLK_I, apb master on CLK_I
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module icc_top
    import icc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CAP_PIN_I,
    input wire logic IDLE_I,
    input wire logic [15:0] SECOND_TIMER_I,
    input wire logic [15:0] THIRD_TIMER_I,
    output logic IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    icc_cap_if cap ();

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic overflow_q;
    logic [1:0] epi_cnt_q;
    logic [ICC_IRQ_W-1:0] stat_q;
    logic [ICC_IRQ_W-1:0] stat_set;
    logic [ICC_IRQ_W-1:0] stat_clr;
    logic [ICC_IRQ_W-1:0] ien_q;
    logic [31:0] rdata_q;

    logic enable;
    logic idle_stop;
    logic first_edge_select;
    logic wide_capture_select;
    logic source_timer_select;
    logic [1:0] events_per_irq;
    icc_mode_t capture_mode_field;

    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    logic sel_ctrl;
    logic sel_data;
    logic sel_stat;
    logic sel_clr;
    logic sel_ien;
    logic addr_hit;
    logic [31:0] ctrl_view;
    logic [31:0] rd_mux;
    logic [31:0] wmask;

    logic run;
    logic [31:0] timer_value;
    logic [15:0] narrow_value;
    logic capture;
    logic overflow_event;
    logic irq_event;
    logic epi_wrap;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // one-hot style address compare used by every select line
    function automatic logic icc_addr_is(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // zero-extend a 16-bit timer word into the 32-bit buffer entry
    function automatic logic [31:0] icc_widen(input logic [15:0] value);
        return {16'h0000, value};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // control field decode

    assign enable = ctrl_q[ICC_ON_BIT];
    assign idle_stop = ctrl_q[ICC_IDLE_STOP_BIT];
    assign first_edge_select = ctrl_q[ICC_FIRST_EDGE_SELECT_BIT];
    assign wide_capture_select = ctrl_q[ICC_WIDE_BIT];
    assign source_timer_select = ctrl_q[ICC_TMR_BIT];
    assign events_per_irq = ctrl_q[ICC_EPI_HI:ICC_EPI_LO];
    assign capture_mode_field = icc_mode_t'(ctrl_q[ICC_MODE_HI:ICC_MODE_LO]);

    // halted while idle only when idle_stop asks for it
    assign run = enable & ~(IDLE_I & idle_stop);

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup = PSEL_I & ~PENABLE_I;
    assign access = PSEL_I & PENABLE_I;
    assign wr_en = access & PWRITE_I;
    assign rd_en = access & ~PWRITE_I;

    assign sel_ctrl = icc_addr_is(PADDR_I, ICC_OFF_CTRL);
    assign sel_data = icc_addr_is(PADDR_I, ICC_OFF_DATA);
    assign sel_stat = icc_addr_is(PADDR_I, ICC_OFF_STAT);
    assign sel_clr = icc_addr_is(PADDR_I, ICC_OFF_CLR);
    assign sel_ien = icc_addr_is(PADDR_I, ICC_OFF_IEN);
    assign addr_hit = sel_ctrl | sel_data | sel_stat | sel_clr | sel_ien;

    // zero wait states; unmapped addresses answer with an error
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access & ~addr_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // capture_control write path

    // mode fields are frozen while the channel is enabled
    assign wmask = enable ? (ICC_CTRL_WMASK & ~ICC_CTRL_LOCK) : ICC_CTRL_WMASK;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en & sel_ctrl) begin
            ctrl_d = (ctrl_q & ~wmask) | (PWDATA_I & wmask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture_control read view

    always_comb begin
        ctrl_view = ctrl_q & ICC_CTRL_WMASK;
        ctrl_view[ICC_OVF_BIT] = overflow_q;
        ctrl_view[ICC_BNE_BIT] = cap.not_empty;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux = ctrl_view;
        end else if (sel_data) begin
            rd_mux = cap.head;
        end else if (sel_stat) begin
            rd_mux = {{(32 - ICC_IRQ_W) {1'b0}}, stat_q};
        end else if (sel_ien) begin
            rd_mux = {{(32 - ICC_IRQ_W) {1'b0}}, ien_q};
        end
    end

    assign PRDATA_O = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // timer source selection

    assign narrow_value = source_timer_select ? SECOND_TIMER_I : THIRD_TIMER_I;
    // wide capture pairs the timers, third timer in the upper half
    assign timer_value = wide_capture_select ? {THIRD_TIMER_I, SECOND_TIMER_I}
                                             : icc_widen(narrow_value);

    ////////////////////////////////////////////////////////////////////////////////
    // edge qualifier and capture buffer

    assign cap.pin = CAP_PIN_I;
    assign cap.mode = capture_mode_field;
    assign cap.first_rise = first_edge_select;
    assign cap.run = run;
    assign cap.clr = ~enable;

    assign capture = cap.hit;
    assign cap.push = capture;
    assign cap.push_data = timer_value;
    // a completed read of the data word retires the head entry
    assign cap.pop = rd_en & sel_data;

    icc_edge u_edge (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cap(cap.edge_q)
    );

    icc_fifo u_fifo (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cap(cap.buf_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // overflow and events-per-interrupt counting

    assign overflow_event = capture & cap.full;
    assign epi_wrap = (epi_cnt_q == events_per_irq);
    assign irq_event = capture & epi_wrap;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            overflow_q <= 1'b0;
        end else if (~enable) begin
            overflow_q <= 1'b0;
        end else if (overflow_event) begin
            overflow_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            epi_cnt_q <= ICC_EPI_RESET;
        end else if (~enable) begin
            epi_cnt_q <= ICC_EPI_RESET;
        end else if (capture) begin
            epi_cnt_q <= epi_wrap ? ICC_EPI_RESET : epi_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable

    always_comb begin
        stat_set = ICC_IRQ_RESET;
        stat_set[ICC_IRQ_CAP] = irq_event;
        stat_set[ICC_IRQ_OVF] = overflow_event;
    end

    assign stat_clr = (wr_en & sel_clr) ? PWDATA_I[ICC_IRQ_W-1:0] : ICC_IRQ_RESET;

    // a new event in the clear cycle survives the clear
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stat_q <= ICC_IRQ_RESET;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ien_q <= ICC_IRQ_RESET;
        end else if (wr_en & sel_ien) begin
            ien_q <= PWDATA_I[ICC_IRQ_W-1:0];
        end
    end

    // disabled channel raises no interrupt
    assign IRQ_O = enable & |(stat_q & ien_q);

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_q <= ICC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // read data is sampled in the setup cycle and held through the access
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup & ~PWRITE_I) begin
            rdata_q <= rd_mux;
        end
    end

endmodule

/* File: shared/icc_pkg.sv */
// constants and types shared by the input capture control block
// assumes a 32-bit apb register side and 16-bit on-chip timers
package icc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] ICC_OFF_CTRL = 8'h00;
    localparam logic [7:0] ICC_OFF_DATA = 8'h04;
    localparam logic [7:0] ICC_OFF_STAT = 8'h08;
    localparam logic [7:0] ICC_OFF_CLR = 8'h0C;
    localparam logic [7:0] ICC_OFF_IEN = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // capture_control field positions
    localparam int ICC_ON_BIT = 15;
    localparam int ICC_IDLE_STOP_BIT = 13;
    localparam int ICC_FIRST_EDGE_SELECT_BIT = 9;
    localparam int ICC_WIDE_BIT = 8;
    localparam int ICC_TMR_BIT = 7;
    localparam int ICC_EPI_HI = 6;
    localparam int ICC_EPI_LO = 5;
    localparam int ICC_OVF_BIT = 4;
    localparam int ICC_BNE_BIT = 3;
    localparam int ICC_MODE_HI = 2;
    localparam int ICC_MODE_LO = 0;

    localparam logic [31:0] ICC_CTRL_RESET = 32'h0000_0000;
    // bits software may store at all, and the subset frozen while enabled
    localparam logic [31:0] ICC_CTRL_WMASK = 32'h0000_A3E7;
    localparam logic [31:0] ICC_CTRL_LOCK = 32'h0000_03E7;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable layout
    localparam int ICC_IRQ_W = 2;
    localparam int ICC_IRQ_CAP = 0;
    localparam int ICC_IRQ_OVF = 1;
    localparam logic [ICC_IRQ_W-1:0] ICC_IRQ_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // capture buffer and counters
    localparam int ICC_DEPTH = 4;
    localparam int ICC_PTR_W = 2;
    localparam int ICC_CNT_W = 3;
    localparam int ICC_PRE_W = 4;
    localparam logic [ICC_PRE_W-1:0] ICC_PRE4_LAST = 4'h3;
    localparam logic [ICC_PRE_W-1:0] ICC_PRE16_LAST = 4'hF;
    localparam logic [1:0] ICC_EPI_RESET = 2'h0;

    typedef enum logic [2:0] {
        ICC_M_OFF = 3'b000,
        ICC_M_EVERY = 3'b001,
        ICC_M_FALL = 3'b010,
        ICC_M_RISE = 3'b011,
        ICC_M_RISE4 = 3'b100,
        ICC_M_RISE16 = 3'b101,
        ICC_M_FIRST = 3'b110,
        ICC_M_RISE_ALT = 3'b111
    } icc_mode_t;

    typedef enum logic {
        ICC_S_WAIT_FIRST = 1'b0,
        ICC_S_ALL = 1'b1
    } icc_edge_state_t;

endpackage

/* File: shared/icc_cap_if.sv */
// signals between the control top, its edge qualifier and its capture buffer
// assumes one clock shared by all three modules
`timescale 1ns/1ps
interface icc_cap_if;
    import icc_pkg::*;
    logic pin;
    icc_mode_t mode;
    logic first_rise;
    logic run;
    logic clr;
    logic hit;
    logic push;
    logic [31:0] push_data;
    logic pop;
    logic [31:0] head;
    logic full;
    logic not_empty;

    modport ctl (output pin, mode, first_rise, run, clr, push, push_data, pop,
                 input hit, head, full, not_empty);
    modport edge_q (input pin, mode, first_rise, run, clr, output hit);
    modport buf_q (input clr, push, push_data, pop, output head, full, not_empty);
endinterface

/* File: hdl/icc_edge.sv */
// edge qualifier: turns pin transitions into capture hits per mode
// assumes the pin is already synchronous to the clock
`timescale 1ns/1ps
module icc_edge
    import icc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    icc_cap_if.edge_q cap
);
    logic pin_q;
    logic [ICC_PRE_W-1:0] pre_q;
    logic [ICC_PRE_W-1:0] pre_d;
    icc_edge_state_t st_q;
    icc_edge_state_t st_d;
    logic rise;
    logic fall;
    logic pre_wrap;
    logic hit_raw;

    assign rise = cap.pin & ~pin_q;
    assign fall = ~cap.pin & pin_q;
    assign pre_wrap = (cap.mode == ICC_M_RISE4) ? (pre_q == ICC_PRE4_LAST)
                                                : (pre_q == ICC_PRE16_LAST);

    always_comb begin
        hit_raw = 1'b0;
        pre_d = pre_q;
        st_d = st_q;
        unique case (cap.mode)
            ICC_M_OFF: hit_raw = 1'b0;
            ICC_M_EVERY: hit_raw = rise | fall;
            ICC_M_FALL: hit_raw = fall;
            ICC_M_RISE, ICC_M_RISE_ALT: hit_raw = rise;
            ICC_M_RISE4, ICC_M_RISE16: begin
                if (rise) begin
                    hit_raw = pre_wrap;
                    pre_d = pre_wrap ? '0 : pre_q + 1'b1;
                end
            end
            ICC_M_FIRST: begin
                unique case (st_q)
                    ICC_S_WAIT_FIRST: begin
                        hit_raw = cap.first_rise ? rise : fall;
                        if (hit_raw) begin
                            st_d = ICC_S_ALL;
                        end
                    end
                    ICC_S_ALL: hit_raw = rise | fall;
                endcase
            end
        endcase
    end

    assign cap.hit = hit_raw & cap.run & ~cap.clr;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 1'b0;
            pre_q <= '0;
            st_q <= ICC_S_WAIT_FIRST;
        end else begin
            pin_q <= cap.pin;
            if (cap.clr) begin
                pre_q <= '0;
                st_q <= ICC_S_WAIT_FIRST;
            end else if (cap.run) begin
                pre_q <= pre_d;
                st_q <= st_d;
            end
        end
    end
endmodule

/* File: hdl/icc_fifo.sv */
// capture buffer: a few words of flip-flops, read at the head
// drops a push itself when full is high, so the writer need not gate it
`timescale 1ns/1ps
module icc_fifo
    import icc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    icc_cap_if.buf_q cap
);
    logic [31:0] mem_q [ICC_DEPTH];
    logic [ICC_PTR_W-1:0] wr_q;
    logic [ICC_PTR_W-1:0] rd_q;
    logic [ICC_CNT_W-1:0] cnt_q;
    logic do_push;
    logic do_pop;

    assign cap.full = (cnt_q == ICC_CNT_W'(ICC_DEPTH));
    assign cap.not_empty = (cnt_q != '0);
    assign do_push = cap.push & ~cap.full;
    assign do_pop = cap.pop & cap.not_empty;
    assign cap.head = cap.not_empty ? mem_q[rd_q] : 32'h0000_0000;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (cap.clr) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push & ~do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop & ~do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= cap.push_data;
        end
    end
endmodule

/* File: sim/icc_monitor.sv */
// concurrent checks on the ports of the input capture control top
// assumes an apb master that keeps to the protocol and the map in icc_pkg
`timescale 1ns/1ps
module icc_monitor
    import icc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CAP_PIN_I,
    input wire logic IDLE_I,
    input wire logic [15:0] SECOND_TIMER_I,
    input wire logic [15:0] THIRD_TIMER_I,
    input wire logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////////////
    logic wr_any;
    logic wr_ctl;
    logic rd_ctl;
    logic rd_dat;
    logic en_q;
    logic idle_stop_q;
    logic [31:0] cfg_q;
    assign wr_any = PSEL_I && PENABLE_I && PWRITE_I;
    assign wr_ctl = wr_any && (PADDR_I == ICC_OFF_CTRL);
    assign rd_ctl = PSEL_I && PENABLE_I && !PWRITE_I && (PADDR_I == ICC_OFF_CTRL);
    assign rd_dat = PSEL_I && PENABLE_I && !PWRITE_I && (PADDR_I == ICC_OFF_DATA);

    // shadow of what software has stored, config only taken while off
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            en_q <= 1'b0;
            idle_stop_q <= 1'b0;
            cfg_q <= 32'h0000_0000;
        end else if (wr_ctl) begin
            en_q <= PWDATA_I[ICC_ON_BIT];
            idle_stop_q <= PWDATA_I[ICC_IDLE_STOP_BIT];
            if (!en_q) begin
                cfg_q <= PWDATA_I & ICC_CTRL_LOCK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    chk_cfg_locked: assert property (rd_ctl |-> (PRDATA_O & ICC_CTRL_LOCK) == cfg_q)
        else $error("config fields differ from last value stored while off");
    chk_enable_readback: assert property (rd_ctl |-> PRDATA_O[ICC_ON_BIT] == en_q)
        else $error("enable bit readback wrong");
    chk_idle_readback: assert property (rd_ctl |-> PRDATA_O[ICC_IDLE_STOP_BIT] == idle_stop_q)
        else $error("idle stop bit readback wrong");
    chk_unused_zero: assert property (rd_ctl |-> PRDATA_O[31:16] == 16'h0000
        && !PRDATA_O[14] && PRDATA_O[12:10] == 3'h0)
        else $error("unimplemented control bits not zero");
    chk_off_flags: assert property (rd_ctl && !en_q && !$past(en_q, 2)
        |-> PRDATA_O[4:3] == 2'b00)
        else $error("status flags set while channel off");
    chk_off_data_zero: assert property (rd_dat && !en_q && !$past(en_q, 2)
        |-> PRDATA_O == 32'h0000_0000)
        else $error("capture data not flushed while off");
    chk_irq_gated: assert property (!en_q |-> !IRQ_O)
        else $error("interrupt raised while channel off");
    chk_irq_cause: assert property ($rose(IRQ_O) |-> $past(wr_any) ||
        ($past(CAP_PIN_I) != $past(CAP_PIN_I, 2) && !($past(IDLE_I) && idle_stop_q)))
        else $error("interrupt rose without a capture edge or write");
endmodule

bind icc_top icc_monitor u_mon (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CAP_PIN_I(CAP_PIN_I),
    .IDLE_I(IDLE_I), .SECOND_TIMER_I(SECOND_TIMER_I), .THIRD_TIMER_I(THIRD_TIMER_I),
    .IRQ_O(IRQ_O));

/* File: sim/icc_far_side.sv */
// far side model: capture pin and two free-running 16-bit timers
// assumes the bench sets the pin level just after a rising edge
`timescale 1ns/1ps
module icc_far_side (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_level_i,
    output logic pin_o,
    output logic [15:0] second_o,
    output logic [15:0] third_o
);
    assign pin_o = pin_level_i;

    // distinct steps so that source and word order mix-ups show
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            second_o <= 16'h0010;
            third_o <= 16'hF000;
        end else begin
            second_o <= second_o + 16'h0001;
            third_o <= third_o + 16'h0103;
        end
    end
endmodule

/* File: sim/test_input_capture_control.sv */
// self-checking bench for the input capture control top over apb
// assumes zero or more apb wait states and the far side model
`timescale 1ns/1ps
module test_input_capture_control
    import icc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_lvl = 1'b0;
    logic pin;
    logic idle = 1'b0;
    logic [15:0] sec;
    logic [15:0] thr;
    logic irq;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] ev_val[$];
    logic ev_rise[$];
    logic [31:0] cfgs[12] = '{32'h21, 32'hE2, 32'h143, 32'h4, 32'h5, 32'h206, 32'h6,
        32'h187, 32'h1, 32'h0, 32'h2003, 32'h3};
    int npl[12] = '{2, 3, 3, 4, 16, 2, 2, 3, 3, 2, 2, 2};

    icc_top DUT (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CAP_PIN_I(pin), .IDLE_I(idle), .SECOND_TIMER_I(sec),
        .THIRD_TIMER_I(thr), .IRQ_O(irq));
    icc_far_side far (.clk_i(clk), .rst_i(rst), .pin_level_i(pin_lvl), .pin_o(pin),
        .second_o(sec), .third_o(thr));

    initial begin
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks made %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(what, exp, q);
    endtask

    // records the timer value the channel should latch for this edge
    task automatic pin_to(input logic v, input logic [31:0] cfg);
        @(posedge clk);
        pin_lvl <= v;
        #1;
        ev_rise.push_back(v);
        ev_val.push_back(cfg[8] ? {thr, sec} : {16'h0, cfg[7] ? sec : thr});
        repeat (2) @(posedge clk);
    endtask

    task automatic run_case(input logic [31:0] cfg, input int n, input logic idl);
        logic [31:0] exp_q[$];
        logic ovf;
        logic hit;
        logic first;
        logic capev;
        int pc;
        int ncap;
        ev_val.delete();
        ev_rise.delete();
        wr(ICC_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        wr(ICC_OFF_CLR, 32'h3);
        wr(ICC_OFF_CTRL, 32'h8000 | cfg);
        idle <= idl;
        for (int i = 0; i < n; i++) begin
            pin_to(1'b1, cfg);
            pin_to(1'b0, cfg);
        end
        idle <= 1'b0;
        ovf = 1'b0;
        first = 1'b0;
        pc = 0;
        ncap = 0;
        foreach (ev_rise[i]) begin
            case (cfg[2:0])
                3'b001: hit = 1'b1;
                3'b010: hit = !ev_rise[i];
                3'b011, 3'b111: hit = ev_rise[i];
                3'b100, 3'b101: begin
                    pc = pc + (ev_rise[i] ? 1 : 0);
                    hit = ev_rise[i] && (pc == (cfg[0] ? 16 : 4));
                    if (hit) pc = 0;
                end
                3'b110: begin
                    hit = first || (ev_rise[i] == cfg[9]);
                    first = first | hit;
                end
                default: hit = 1'b0;
            endcase
            if (idl && cfg[13]) hit = 1'b0;
            if (hit) begin
                ncap++;
                if (exp_q.size() < 4) exp_q.push_back(ev_val[i]);
                else ovf = 1'b1;
            end
        end
        capev = ncap > int'(cfg[6:5]);
        rd(ICC_OFF_CTRL, 32'h8000 | cfg | {ovf, exp_q.size() != 0, 3'h0}, "ctl");
        rd(ICC_OFF_STAT, {30'h0, ovf, capev}, "status");
        chk("irq", {31'h0, capev | ovf}, {31'h0, irq});
        foreach (exp_q[i]) rd(ICC_OFF_DATA, exp_q[i], "capture");
        rd(ICC_OFF_DATA, 32'h0, "empty data");
        rd(ICC_OFF_CTRL, 32'h8000 | cfg | {ovf, 4'h0}, "ctl drained");
        $display("case cfg %h done, %0d captures", cfg, ncap);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(ICC_OFF_CTRL, 32'h0, "ctl reset");
        rd(ICC_OFF_STAT, 32'h0, "status reset");
        rd(ICC_OFF_IEN, 32'h0, "irq enable reset");
        rd(ICC_OFF_DATA, 32'h0, "data reset");
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        wr(ICC_OFF_CTRL, 32'hFFFF_FFFF);
        rd(ICC_OFF_CTRL, 32'h0000_A3E7, "ctl all ones");
        wr(ICC_OFF_CTRL, 32'h0000_8000);
        rd(ICC_OFF_CTRL, 32'h0000_83E7, "ctl locked");
        wr(ICC_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        rd(ICC_OFF_CTRL, 32'h0000_03E7, "ctl off");
        wr(ICC_OFF_IEN, 32'h3);
        rd(ICC_OFF_IEN, 32'h3, "irq enable");
        $display("register tests done");
        for (int i = 0; i < 12; i++) begin
            run_case(cfgs[i], npl[i], i >= 10);
        end
        wr(ICC_OFF_IEN, 32'h0);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(ICC_OFF_IEN, 32'h1);
        #1;
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(ICC_OFF_CLR, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(ICC_OFF_STAT, 32'h0, "status cleared");
        $display("interrupt tests done");
        // leave one entry unread, then disabling must flush it
        wr(ICC_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        wr(ICC_OFF_CTRL, 32'h8001);
        pin_to(1'b1, 32'h1);
        rd(ICC_OFF_CTRL, 32'h0000_8009, "ctl one entry");
        wr(ICC_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        rd(ICC_OFF_DATA, 32'h0, "flushed data");
        rd(ICC_OFF_CTRL, 32'h0000_0001, "ctl flushed");
        $display("flush tests done");
        report_and_stop();
    end

    initial begin
        #2_000_000;
        err_total++;
        report_and_stop();
    end
endmodule
